// [hdl/adcl_scan_ctrl.sv]
// Purpose: Digital control of an eight-channel converter: timing, selects, scan, readout
// Assumes: START is convert-start, high for acquisition; SCK idles between frames
// Notes: SDO is a mux of a held word by the SCK-side bit counter
`timescale 1ns/1ns
module adcl_scan_ctrl (
  input wire logic CLK_SYS, // System clock, 10 MHz
  input wire logic RST_B, // Asynchronous reset, active low
  input wire logic SCK, // Serial clock from host
  input wire logic START, // Convert-start pin, high acquires
  input wire logic [adcl_pkg::CHAN_BITS-1:0] CHAN_SEL, // Channel select pins
  input wire logic [adcl_pkg::GAIN_BITS-1:0] GAIN_SEL, // Gain select pins
  input wire logic BYPASS_SEL, // Amplifier bypass pin
  input wire logic LOW_POWER_SEL, // Low power mode pin
  input wire logic SCAN_SEL, // Scan sequencer enable pin
  input wire logic [adcl_pkg::RAW_BITS-1:0] RAW_CODE, // Signed code from converter core
  output logic SDO_OUT, // Serial data output
  output logic SDO_OE_N, // SDO driver enable, low drives
  output logic BUSY, // Conversion in progress
  output logic ACQUIRE, // Sampler tracking the input
  output logic CONV_START, // One-cycle pulse at the sampling instant
  output logic [adcl_pkg::CHAN_BITS-1:0] CHAN_ACTIVE, // Channel fed to converter
  output logic [adcl_pkg::GAIN_BITS-1:0] GAIN_ACTIVE, // Gain code applied
  output logic BYPASS_ACTIVE, // Amplifier bypassed
  output logic [4:0] GAIN_FACTOR // Numeric gain applied
);
  import adcl_pkg::*;

  logic start_m_q, start_s_q, start_d_q;
  adcl_pins_t pins_m_q, pins_s_q;
  logic start_rise, start_fall;
  logic [CHAN_BITS-1:0] seq_q, seq_d, chan_pick;
  logic scan_act_q;
  adcl_sel_t lat_q, prev_q, act_q;
  logic busy_q, done_q;
  logic [CONV_CNT_BITS-1:0] conv_cnt_q, conv_lim;
  logic [RES_BITS-1:0] code_d;
  logic [WORD_BITS-1:0] word_q;
  logic frame_clr_q, oe_n_q, acq_q;
  logic sck_rst_b;
  logic [BIT_CNT_BITS-1:0] bit_cnt_q, bit_idx;

  // Two-stage synchronisers for the pins
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      start_m_q <= 1'b0;
      start_s_q <= 1'b0;
      start_d_q <= 1'b0;
      pins_m_q <= '0;
      pins_s_q <= '0;
    end else begin
      start_m_q <= START;
      start_s_q <= start_m_q;
      start_d_q <= start_s_q;
      pins_m_q <= {SCAN_SEL, LOW_POWER_SEL, BYPASS_SEL, CHAN_SEL, GAIN_SEL};
      pins_s_q <= pins_m_q;
    end
  end

  assign start_rise = start_s_q && !start_d_q;
  assign start_fall = !start_s_q && start_d_q;

  // Sequencer next value and the channel to capture at this rise
  always_comb begin
    seq_d = seq_q;
    chan_pick = pins_s_q.chan;
    if (pins_s_q.scan) begin
      if (!scan_act_q) begin
        seq_d = pins_s_q.low_pwr ? SEQ_SEED_LOWP : SEQ_SEED_NORM;
      end else begin
        seq_d = seq_q + 3'h1;
      end
      chan_pick = seq_d;
    end else if (scan_act_q) begin
      seq_d = seq_q + 3'h1;
      chan_pick = seq_d;
    end
  end

  // Scan state updates only on START rises
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      seq_q <= CHAN_RST;
      scan_act_q <= 1'b0;
    end else if (start_rise) begin
      seq_q <= seq_d;
      scan_act_q <= pins_s_q.scan;
    end
  end

  // Select capture on the rise; previous capture kept for normal mode
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      lat_q <= '0;
      prev_q <= '0;
    end else if (start_rise) begin
      lat_q <= '{bypass: pins_s_q.bypass, chan: chan_pick, gain: pins_s_q.gain};
      prev_q <= lat_q;
    end
  end

  // Applied selection fixed at the sampling instant
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      act_q <= '0;
    end else if (start_fall) begin
      act_q <= pins_s_q.low_pwr ? lat_q : prev_q;
    end
  end

  assign conv_lim = act_q.bypass ? CONV_CNT_BITS'(CONV_BYP_CYC) : CONV_CNT_BITS'(CONV_AMP_CYC);

  // Conversion timer, independent of SCK
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      conv_cnt_q <= '0;
    end else begin
      done_q <= 1'b0;
      if (start_fall) begin
        busy_q <= 1'b1;
        conv_cnt_q <= CONV_CNT_BITS'(1);
      end else if (busy_q) begin
        if (conv_cnt_q >= conv_lim) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          conv_cnt_q <= conv_cnt_q + CONV_CNT_BITS'(1);
        end
      end
    end
  end

  // Saturate the core code so it never wraps
  always_comb begin
    if ($signed(RAW_CODE) > RAW_MAX) begin
      code_d = CODE_MAX;
    end else if ($signed(RAW_CODE) < RAW_MIN) begin
      code_d = CODE_MIN;
    end else begin
      code_d = RAW_CODE[RES_BITS-1:0];
    end
  end

  // Output word held from conversion end until the next one
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      word_q <= WORD_RST;
    end else if (busy_q && conv_cnt_q >= conv_lim) begin
      word_q <= {code_d, act_q.chan, act_q.gain};
    end
  end

  // Frame clear keeps the SCK counter at zero outside readout
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      frame_clr_q <= 1'b1;
      oe_n_q <= 1'b1;
      acq_q <= 1'b0;
    end else begin
      frame_clr_q <= start_s_q || start_fall || busy_q && conv_cnt_q < conv_lim;
      oe_n_q <= start_s_q;
      acq_q <= pins_s_q.low_pwr ? start_s_q : !busy_q;
    end
  end

  // Release of the clear happens while SCK is idle, so no SCK-side race
  assign sck_rst_b = RST_B && !frame_clr_q;

  // SCK-side bit counter, saturates so extra edges shift zeros
  always_ff @(posedge SCK or negedge sck_rst_b) begin
    if (!sck_rst_b) begin
      bit_cnt_q <= '0;
    end else if (bit_cnt_q < BIT_CNT_BITS'(WORD_BITS)) begin
      bit_cnt_q <= bit_cnt_q + BIT_CNT_BITS'(1);
    end
  end

  assign bit_idx = BIT_CNT_BITS'(WORD_BITS - 1) - bit_cnt_q;

  // Word held stable while SCK runs, so the mux output is glitch-safe per bit
  assign SDO_OUT = (bit_cnt_q < BIT_CNT_BITS'(WORD_BITS)) ? word_q[bit_idx] : 1'b0;
  assign SDO_OE_N = oe_n_q;
  assign BUSY = busy_q;
  assign ACQUIRE = acq_q;
  assign CHAN_ACTIVE = act_q.chan;
  assign GAIN_ACTIVE = act_q.gain;
  assign BYPASS_ACTIVE = act_q.bypass;

  // Gain factor registered for the analog gain stage
  always_ff @(posedge CLK_SYS or negedge RST_B) begin
    if (!RST_B) begin
      GAIN_FACTOR <= GAIN_FACTOR_LUT[0];
      CONV_START <= 1'b0;
    end else begin
      GAIN_FACTOR <= GAIN_FACTOR_LUT[act_q.gain];
      CONV_START <= start_fall;
    end
  end

  // Checks on the system clock domain
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RST_B);

  a_busy_rise: assert property (start_fall |=> busy_q && $rose(busy_q))
    else $error("busy did not rise after sampling instant");
  a_byp_conv_time: assert property (start_fall && lat_q.bypass && pins_s_q.low_pwr
      |=> busy_q [*6] ##1 !busy_q)
    else $error("bypassed conversion length wrong");
  // Fifteen busy cycles split in two runs to keep each repetition short
  a_amp_conv_time: assert property (start_fall && !lat_q.bypass && pins_s_q.low_pwr
      |=> busy_q [*8] ##1 busy_q [*7] ##1 !busy_q)
    else $error("amplifier conversion length wrong");
  a_select_capture: assert property (start_rise && !pins_s_q.scan && !scan_act_q
      |=> lat_q.chan == $past(pins_s_q.chan) && lat_q.gain == $past(pins_s_q.gain))
    else $error("select pins not captured on rise");
  a_lowp_same_sample: assert property (start_fall && pins_s_q.low_pwr
      |=> act_q == $past(lat_q))
    else $error("low power select not applied to same sample");
  a_norm_delay: assert property (start_fall && !pins_s_q.low_pwr |=> act_q == $past(prev_q))
    else $error("normal mode select not delayed one sample");
  a_clamp_high: assert property (busy_q && conv_cnt_q >= conv_lim && $signed(RAW_CODE) > RAW_MAX
      |=> word_q[WORD_BITS-1 -: RES_BITS] == CODE_MAX)
    else $error("positive clamp missing");
  a_scan_wrap: assert property (start_rise && pins_s_q.scan && scan_act_q && seq_q == 3'h7
      |=> seq_q == 3'h0 && lat_q.chan == 3'h0)
    else $error("sequencer did not wrap to zero");
  a_scan_exit: assert property (start_rise && !pins_s_q.scan && scan_act_q
      |=> lat_q.chan == $past(seq_q) + 3'h1 ##1 !scan_act_q)
    else $error("no trailing sequencer sample after scan");
  a_oe_follow: assert property (start_s_q |=> SDO_OE_N)
    else $error("SDO driven while START high");
  a_word_chan: assert property ($fell(busy_q) |-> word_q[GAIN_BITS +: CHAN_BITS] == act_q.chan)
    else $error("trailing channel bits wrong");

  c_byp_conv: cover property (start_fall && lat_q.bypass ##[1:10] $fell(busy_q));
  c_scan_wrap: cover property (start_rise && scan_act_q && seq_q == 3'h7);
  c_scan_exit: cover property (start_rise && !pins_s_q.scan && scan_act_q);
  c_lowp_conv: cover property (start_fall && pins_s_q.low_pwr ##[1:20] $fell(busy_q));

endmodule // adcl_scan_ctrl

// [hdl/adcl_pkg.sv]
// Purpose: Shared constants and types for the low-power scan converter control
// Assumes: CLK_SYS at 10 MHz; SCK is the host's serial clock
// Notes: Cycle counts derive from printed times and the clock period
package adcl_pkg;
  // Clock rate
  localparam int CLK_PERIOD_NS = 100;
  // Conversion times, longest allowed, so round down
  localparam int CONV_BYP_NS = 660;
  localparam int CONV_AMP_NS = 1550;
  localparam int CONV_BYP_CYC = (CONV_BYP_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_BYP_NS / CLK_PERIOD_NS;
  localparam int CONV_AMP_CYC = (CONV_AMP_NS / CLK_PERIOD_NS < 1) ? 1 : CONV_AMP_NS / CLK_PERIOD_NS;
  // Host obligations, kept for reference by the bench
  localparam int START_HIGH_LOWP_NS = 500;
  localparam int START_HIGH_NORM_NS = 150;
  // Word layout
  localparam int RES_BITS = 14;
  localparam int CHAN_BITS = 3;
  localparam int GAIN_BITS = 3;
  localparam int RAW_BITS = 16;
  localparam int WORD_BITS = RES_BITS + CHAN_BITS + GAIN_BITS;
  localparam int CONV_CNT_BITS = 4;
  localparam int BIT_CNT_BITS = 5;
  // Clamp limits
  localparam logic signed [RAW_BITS-1:0] RAW_MAX = 16'sh1fff;
  localparam logic signed [RAW_BITS-1:0] RAW_MIN = -16'sh2000;
  localparam logic [RES_BITS-1:0] CODE_MAX = 14'h1fff;
  localparam logic [RES_BITS-1:0] CODE_MIN = 14'h2000;
  // Sequencer seeds: low power needs one wasted step before channel 0
  localparam logic [CHAN_BITS-1:0] SEQ_SEED_LOWP = 3'h7;
  localparam logic [CHAN_BITS-1:0] SEQ_SEED_NORM = 3'h0;
  // Reset values
  localparam logic [CHAN_BITS-1:0] CHAN_RST = 3'h0;
  localparam logic [GAIN_BITS-1:0] GAIN_RST = 3'h0;
  localparam logic [WORD_BITS-1:0] WORD_RST = 20'h00000;
  // Gain factor per gain code
  localparam logic [4:0] GAIN_FACTOR_LUT [8] = '{5'h01, 5'h02, 5'h03, 5'h04,
                                                  5'h06, 5'h08, 5'h0c, 5'h10};
  // Synchronised select pins
  typedef struct packed {
    logic scan;
    logic low_pwr;
    logic bypass;
    logic [CHAN_BITS-1:0] chan;
    logic [GAIN_BITS-1:0] gain;
  } adcl_pins_t;
  // Selection applied to one conversion
  typedef struct packed {
    logic bypass;
    logic [CHAN_BITS-1:0] chan;
    logic [GAIN_BITS-1:0] gain;
  } adcl_sel_t;
endpackage

// [testbench/adcl_host_model.sv]
// Purpose: Host side serial reader for the converter control
// Assumes: Link clock of 48 ns, unrelated to the system clock
// Notes: SCK stands still between frames
`timescale 1ns/1ns
module adcl_host_model (
  input wire logic go, // Start a frame
  input wire logic [4:0] n, // Rising edges to give
  input wire logic sdo, // Data line level
  output logic sck, // Serial clock
  output logic [19:0] word, // Bits read, last in lsb
  output logic done // Frame finished
);
  logic lclk;
  // Free link clock; only a gated copy reaches the pin
  initial begin
    lclk = 1'b0;
    #7;
    forever #24 lclk = ~lclk;
  end
  // Sample ahead of each rise, because the next bit moves just after it
  initial begin
    sck = 1'b0;
    word = 20'h00000;
    done = 1'b0;
    forever begin
      @(posedge go);
      word = 20'h00000;
      for (int i = 0; i < n; i++) begin
        @(posedge lclk);
        word = {word[18:0], sdo};
        sck = 1'b1;
        @(negedge lclk);
        sck = 1'b0;
      end
      done = 1'b1;
      @(negedge go);
      done = 1'b0;
    end
  end
endmodule // adcl_host_model

// [testbench/adcl_scan_ctrl_tb.sv]
// Purpose: Self-checking bench for the converter control
// Assumes: 10 MHz system clock, host reader on its own clock
// Notes: Selects change only while idle, never while busy
`timescale 1ns/1ns
module adcl_scan_ctrl_tb;
  import adcl_pkg::*;
  logic clk_sys = 1'b0, rst_b = 1'b0, start = 1'b0, bypass = 1'b1, low_pwr = 1'b1;
  logic byp_prev = 1'b0, cs_pulse;
  logic [2:0] gain_prev = 3'h0;
  logic scan = 1'b0, go = 1'b0, sdo_last = 1'b0;
  logic [2:0] chan = 3'h0, gain = 3'h0;
  logic [15:0] raw = 16'h0000;
  logic [4:0] nb = 5'h14;
  logic sdo, oe_n, busy, acq, byp_a, sck, done;
  logic [2:0] chan_a, gain_a;
  logic [4:0] gfac;
  logic [19:0] word;
  logic [15:0] raw_tbl [4] = '{16'h1fff, 16'h2000, 16'hdfff, 16'h0abc};
  logic [4:0] gf_tbl [8] = '{5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h08, 5'h0c, 5'h10};
  int bad_count = 0, compares = 0;
  // A released line must not show its last bit
  wire logic sdo_w = oe_n ? ~sdo_last : sdo;
  always #50 clk_sys = ~clk_sys;
  always @(posedge clk_sys) if (!oe_n) sdo_last <= sdo;
  adcl_scan_ctrl dut_u (.CLK_SYS(clk_sys), .RST_B(rst_b), .SCK(sck), .START(start),
    .CHAN_SEL(chan), .GAIN_SEL(gain), .BYPASS_SEL(bypass), .LOW_POWER_SEL(low_pwr),
    .SCAN_SEL(scan), .RAW_CODE(raw), .SDO_OUT(sdo), .SDO_OE_N(oe_n), .BUSY(busy),
    .ACQUIRE(acq), .CONV_START(cs_pulse), .CHAN_ACTIVE(chan_a), .GAIN_ACTIVE(gain_a),
    .BYPASS_ACTIVE(byp_a), .GAIN_FACTOR(gfac));
  adcl_host_model host_u (.go(go), .n(nb), .sdo(sdo_w), .sck(sck), .word(word), .done(done));
  // Compare and count
  task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic stop_test();
    if (bad_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // One sample with a readout of n bits, then checks against channel c
  task automatic run(input logic [4:0] n, input logic [2:0] c);
    int k;
    logic [13:0] code;
    logic byp_e;
    logic [2:0] gain_e;
    repeat (3) @(posedge clk_sys);
    // Normal mode applies the selects captured one sample earlier
    byp_e = low_pwr ? bypass : byp_prev;
    gain_e = low_pwr ? gain : gain_prev;
    byp_prev = bypass;
    gain_prev = gain;
    start <= 1'b1;
    repeat (6) @(posedge clk_sys);
    chk("oe_n", 20'h1, {19'h0, oe_n});
    if (low_pwr) chk("acquire", 20'h1, {19'h0, acq});
    start <= 1'b0;
    k = 0;
    while (busy !== 1'b1 && k < 10) begin
      @(posedge clk_sys);
      k++;
    end
    // The start pulse stands in the first busy cycle only
    chk("conv start", 20'h1, {19'h0, cs_pulse});
    k = 0;
    while (busy === 1'b1 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    chk("busy cycles", 20'(byp_e ? CONV_BYP_CYC : CONV_AMP_CYC), 20'(k));
    repeat (2) @(posedge clk_sys);
    nb <= n;
    go <= 1'b1;
    k = 0;
    while (done !== 1'b1 && k < 40) begin
      @(posedge clk_sys);
      k++;
    end
    chk("frame done", 20'h1, {19'h0, done});
    go <= 1'b0;
    @(posedge clk_sys);
    chk("oe_n low", 20'h0, {19'h0, oe_n});
    if ($signed(raw) > RAW_MAX) code = CODE_MAX;
    else if ($signed(raw) < RAW_MIN) code = CODE_MIN;
    else code = raw[13:0];
    chk("word", {code, c, gain_e} >> (20 - n), word);
    chk("chan active", {17'h0, c}, {17'h0, chan_a});
    chk("gain active", {17'h0, gain_e}, {17'h0, gain_a});
    chk("bypass active", {19'h0, byp_e}, {19'h0, byp_a});
  endtask
  // Main sequence; selects move only between samples
  initial begin
    repeat (5) @(posedge clk_sys);
    rst_b <= 1'b1;
    // Low power, bypassed: clamp ends and short trailing reads
    for (int i = 0; i < 4; i++) begin
      raw <= raw_tbl[i];
      chan <= 3'(i + 5);
      gain <= 3'(i + 2);
      run(5'(14 + 2 * i), 3'(i + 5));
    end
    // Amplifier on: every gain code
    bypass <= 1'b0;
    for (int g = 0; g < 8; g++) begin
      gain <= 3'(g);
      run(5'h14, 3'h0);
      chk("gain factor", {15'h0, gf_tbl[g]}, {15'h0, gfac});
    end
    // Normal mode: selects apply one sample late
    low_pwr <= 1'b0;
    bypass <= 1'b1;
    chan <= 3'h1;
    gain <= 3'h3;
    run(5'h14, 3'h0);
    chan <= 3'h2;
    run(5'h14, 3'h1);
    // Low power scan: channel pins ignored, first sample wasted, wrap past 7
    low_pwr <= 1'b1;
    chan <= 3'h6;
    scan <= 1'b1;
    run(5'h0, 3'h7);
    for (int i = 0; i < 10; i++) run(5'h14, 3'(i));
    scan <= 1'b0;
    run(5'h14, 3'h2);
    run(5'h14, 3'h6);
    // Normal scan: channel 0 on the second sample
    low_pwr <= 1'b0;
    scan <= 1'b1;
    run(5'h0, 3'h6);
    run(5'h14, 3'h0);
    run(5'h14, 3'h1);
    stop_test();
  end
  // Watchdog well past the expected run length
  initial begin
    #1000000;
    bad_count++;
    stop_test();
  end
endmodule // adcl_scan_ctrl_tb
